/* logic/frd_pkg.sv */
/*
 * Shared constants, types and the checksum function of the flow reading
 * format block. Assumes one system clock and a synchronous reset.
 */
package frd_pkg;

    // widths and depth of the reading path
    localparam int WORD_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 16;

    // word checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // flow-unit word layout
    localparam int PFX_LSB     = 0;
    localparam int PFX_W       = 4;
    localparam int TBASE_LSB   = 4;
    localparam int TBASE_W     = 4;
    localparam int UNIT_LSB    = 8;
    localparam int UNIT_W      = 5;
    localparam int UNIT_USED_W = 13;

    // documented unit codes
    localparam logic [3:0]  PFX_ONE     = 4'h8;
    localparam logic [3:0]  TBASE_MIN   = 4'h4;
    localparam logic [4:0]  UNIT_SLITER = 5'h01;
    localparam logic [15:0] UNIT_SLM    = 16'h0148;

    // conversion figures applied by the consumer of the readings
    localparam int FLOW_SCALE  = 170;
    localparam int FLOW_OFFSET = -24576;
    localparam int TEMP_SCALE  = 200;
    localparam int TEMP_OFFSET = 0;

    typedef enum logic [1:0] {
        KIND_FLOW = 2'h0,
        KIND_TEMP = 2'h1,
        KIND_UNIT = 2'h2
    } frd_kind_t;

    typedef struct packed {
        frd_kind_t          kind;
        logic [WORD_W-1:0]  data;
    } frd_word_t;

    typedef struct packed {
        frd_kind_t          kind;
        logic               last;
        logic [BYTE_W-1:0]  data;
    } frd_byte_t;

    typedef struct packed {
        logic [UNIT_W-1:0]  unit;
        logic [TBASE_W-1:0] tbase;
        logic [PFX_W-1:0]   prefix;
    } frd_unit_t;

    // checksum over one 16-bit word, msb first, no reflection, no final xor
    function automatic logic [7:0] crc8(input logic [WORD_W-1:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

endpackage

/* logic/frd_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes the drain side may stall; in_ready is registered.
 */
`timescale 1ns/1ns
module frd_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
    } frd_fifo_st_t;

    frd_fifo_st_t     st_q;
    frd_fifo_st_t     st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push    = i_valid && st_q.rdy;
    assign pop     = i_ready && (st_q.cnt != '0);
    assign o_valid = (st_q.cnt != '0);
    assign o_data  = mem[st_q.rp];
    assign o_ready = st_q.rdy;

    // pointer and count update; ready drops once the buffer is full
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        st_d.rdy = (st_d.cnt < (AW+1)'(DEPTH));
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // storage
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[st_q.wp] <= i_data;
        end
    end

endmodule

/* logic/frd_reading_tx.sv */
/*
 * Reading word formatter: buffers flow, temperature and unit words and
 * sends each as high byte, low byte and checksum byte; decodes unit words.
 * Assumes the word source and byte consumer run on i_mclk.
 */
`timescale 1ns/1ns
module frd_reading_tx (
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    input  wire frd_pkg::frd_word_t i_word,
    input  wire logic              i_word_valid,
    output logic                   o_word_ready,
    output frd_pkg::frd_byte_t     o_byte,
    output logic                   o_byte_valid,
    input  wire logic              i_byte_ready,
    output frd_pkg::frd_unit_t     o_unit,
    output logic                   o_unit_known
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HI   = 2'b01,
        ST_LO   = 2'b11,
        ST_CRC  = 2'b10
    } frd_state_t;

    typedef struct packed {
        frd_state_t                   state;
        logic [frd_pkg::WORD_W-1:0]   word;
        logic [7:0]                   crc;
        frd_pkg::frd_byte_t           out;
        logic                         valid;
        frd_pkg::frd_unit_t           unit;
        logic                         known;
    } frd_tx_st_t;

    frd_tx_st_t          st_q;
    frd_tx_st_t          st_d;
    frd_pkg::frd_word_t  fifo_word;
    logic                fifo_valid;
    logic                fifo_pop;
    logic                fifo_ready;
    logic [frd_pkg::WORD_W-1:0] clean_word;
    logic                accepted;

    // word buffer between source and byte sender
    frd_fifo #(
        .WIDTH ($bits(frd_pkg::frd_word_t)),
        .DEPTH (frd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_data    (i_word),
        .i_valid   (i_word_valid),
        .o_ready   (fifo_ready),
        .o_data    (fifo_word),
        .o_valid   (fifo_valid),
        .i_ready   (fifo_pop)
    );

    assign o_word_ready = fifo_ready;
    assign fifo_pop     = (st_q.state == ST_IDLE);
    assign accepted     = st_q.valid && i_byte_ready;

    // unit words carry no information above bit 12; signed readings pass untouched
    always_comb begin
        clean_word = fifo_word.data;
        if (fifo_word.kind == frd_pkg::KIND_UNIT) begin
            clean_word = {{(frd_pkg::WORD_W-frd_pkg::UNIT_USED_W){1'b0}},
                          fifo_word.data[frd_pkg::UNIT_USED_W-1:0]};
        end
    end

    // byte sequencer and unit decoder
    always_comb begin
        st_d = st_q;
        unique case (st_q.state)
            ST_IDLE: begin
                if (fifo_valid) begin
                    st_d.word     = clean_word;
                    st_d.crc      = frd_pkg::crc8(clean_word);
                    st_d.out.kind = fifo_word.kind;
                    st_d.out.last = 1'b0;
                    st_d.out.data = clean_word[15:8];
                    st_d.valid    = 1'b1;
                    st_d.state    = ST_HI;
                    if (fifo_word.kind == frd_pkg::KIND_UNIT) begin
                        st_d.unit.prefix = clean_word[frd_pkg::PFX_LSB +: frd_pkg::PFX_W];
                        st_d.unit.tbase  = clean_word[frd_pkg::TBASE_LSB +: frd_pkg::TBASE_W];
                        st_d.unit.unit   = clean_word[frd_pkg::UNIT_LSB +: frd_pkg::UNIT_W];
                        st_d.known       = (clean_word == frd_pkg::UNIT_SLM);
                    end
                end
            end
            ST_HI: begin
                if (accepted) begin
                    st_d.out.data = st_q.word[7:0];
                    st_d.state    = ST_LO;
                end
            end
            ST_LO: begin
                if (accepted) begin
                    st_d.out.data = st_q.crc;
                    st_d.out.last = 1'b1;
                    st_d.state    = ST_CRC;
                end
            end
            ST_CRC: begin
                if (accepted) begin
                    st_d.valid    = 1'b0;
                    st_d.out.last = 1'b0;
                    st_d.state    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_q <= '{state: ST_IDLE, word: '0, crc: '0, out: '0, valid: 1'b0,
                      unit: '0, known: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_byte       = st_q.out;
    assign o_byte_valid = st_q.valid;
    assign o_unit       = st_q.unit;
    assign o_unit_known = st_q.known;

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence hi_sent;
        o_byte_valid && i_byte_ready && !o_byte.last && st_q.state == ST_HI;
    endsequence

    byte_order_a: assert property (hi_sent |=> st_q.state == ST_LO &&
        o_byte.data == st_q.word[7:0] && o_byte_valid)
        else $error("low byte does not follow high byte");

    crc_value_a: assert property (o_byte_valid && o_byte.last |->
        o_byte.data == frd_pkg::crc8(st_q.word))
        else $error("checksum byte wrong");

    crc_after_lo_a: assert property (st_q.state == ST_LO && accepted |=>
        o_byte.last && o_byte_valid ##0 o_byte.data == st_q.crc)
        else $error("checksum byte not sent after low byte");

    hold_byte_a: assert property (o_byte_valid && !i_byte_ready |=>
        o_byte_valid && $stable(o_byte))
        else $error("byte changed while stalled");

    unit_mask_a: assert property (st_q.state != ST_IDLE &&
        o_byte.kind == frd_pkg::KIND_UNIT |-> st_q.word[15:13] == 3'h0)
        else $error("unit word upper bits not cleared");

    unit_field_a: assert property ($changed(o_unit) |->
        o_unit == st_q.word[frd_pkg::UNIT_USED_W-1:0])
        else $error("unit fields misplaced");

    unit_known_a: assert property (o_unit_known |->
        o_unit.unit == frd_pkg::UNIT_SLITER && o_unit.tbase == frd_pkg::TBASE_MIN &&
        o_unit.prefix == frd_pkg::PFX_ONE)
        else $error("unit flagged known for other codes");

    take_word_a: assert property (st_q.state == ST_IDLE && fifo_valid |=>
        o_byte_valid && o_byte.data == st_q.word[15:8] ##1 1'b1)
        else $error("high byte not presented after word taken");

endmodule

/* bench/frd_byte_sink.sv */
/*
 * Byte consumer model: takes checksummed bytes and keeps them in order.
 * Assumes i_mclk and i_sys_rst are those of the formatter it faces.
 */
`timescale 1ns/1ns
module frd_byte_sink (
    input  wire logic               i_mclk,
    input  wire logic               i_sys_rst,
    input  wire frd_pkg::frd_byte_t i_byte,
    input  wire logic               i_byte_valid,
    input  wire logic [1:0]         i_mode,
    output logic                    o_byte_ready
);
    frd_pkg::frd_byte_t got[$];
    logic               tog_q;
    logic [15:0]        word_q;
    int                 flow_slm;
    int                 temp_c;
    logic               unit_ok;

    // mode 0 always ready, 1 stalled, 2 ready every other cycle
    assign o_byte_ready = (i_mode == 2'h0) | ((i_mode == 2'h2) & tog_q);

    // record each accepted byte: high, low, checksum
    always_ff @(posedge i_mclk) begin
        tog_q <= i_sys_rst ? 1'b0 : ~tog_q;
        if (!i_sys_rst && i_byte_valid && o_byte_ready) begin
            got.push_back(i_byte);
        end
    end

    // rebuild each word; at its checksum byte convert flow and temperature to physical values or check the unit code
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            word_q   <= '0;
            flow_slm <= 0;
            temp_c   <= 0;
            unit_ok  <= 1'b0;
        end else if (i_byte_valid && o_byte_ready) begin
            if (!i_byte.last) begin
                word_q <= {word_q[7:0], i_byte.data};
            end else if (i_byte.kind == frd_pkg::KIND_FLOW) begin
                flow_slm <= (int'($signed(word_q)) - frd_pkg::FLOW_OFFSET)
                            / frd_pkg::FLOW_SCALE;
            end else if (i_byte.kind == frd_pkg::KIND_TEMP) begin
                temp_c <= (int'($signed(word_q)) - frd_pkg::TEMP_OFFSET)
                          / frd_pkg::TEMP_SCALE;
            end else begin
                // bits 15..13 ignored, any other code is unrecognised
                unit_ok <= (word_q[12:8] == frd_pkg::UNIT_SLITER) &&
                           (word_q[7:4] == frd_pkg::TBASE_MIN) &&
                           (word_q[3:0] == frd_pkg::PFX_ONE);
            end
        end
    end
endmodule

/* bench/tb_top.sv */
/*
 * Testbench of the reading word formatter.
 * Assumes frd_pkg, frd_fifo, frd_reading_tx and frd_byte_sink are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
    logic                   i_mclk = 1'b0;
    logic                   i_sys_rst = 1'b1;
    logic                   i_word_valid = 1'b0;
    logic [1:0]             mode = 2'h0;
    logic                   o_word_ready;
    logic                   o_byte_valid;
    logic                   i_byte_ready;
    logic                   o_unit_known;
    frd_pkg::frd_word_t     i_word = '0;
    frd_pkg::frd_byte_t     o_byte;
    frd_pkg::frd_unit_t     o_unit;
    frd_pkg::frd_byte_t     exp_q[$];
    int                     bad_count = 0;
    int                     tests_run = 0;

    // 100 MHz clock
    always #5 i_mclk = ~i_mclk;

    frd_reading_tx DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_word(i_word),
        .i_word_valid(i_word_valid), .o_word_ready(o_word_ready), .o_byte(o_byte),
        .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready), .o_unit(o_unit),
        .o_unit_known(o_unit_known));

    frd_byte_sink SINK (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_byte(o_byte),
        .i_byte_valid(o_byte_valid), .i_mode(mode), .o_byte_ready(i_byte_ready));

    // independent checksum, msb first
    function automatic logic [7:0] crc_ref(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // offer one word, hold it until taken or the bound runs out
    task automatic push(input frd_pkg::frd_word_t w, input int lim, output bit ok);
        i_word <= w;
        i_word_valid <= 1'b1;
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge i_mclk);
            ok = o_word_ready;
        end
        if (ok) begin
            logic [15:0] m;
            m = (w.kind == frd_pkg::KIND_UNIT) ? {3'h0, w.data[12:0]} : w.data;
            exp_q.push_back({w.kind, 1'b0, m[15:8]});
            exp_q.push_back({w.kind, 1'b0, m[7:0]});
            exp_q.push_back({w.kind, 1'b1, crc_ref(m)});
        end
    endtask

    task automatic send(input frd_pkg::frd_kind_t k, input logic [15:0] d);
        bit ok;
        push({k, d}, 40, ok);
        if (!ok) begin
            bad_count++;
            finish_test();
        end
    endtask

    // release the word line, wait for every byte, compare in order
    task automatic drain;
        int n;
        i_word_valid <= 1'b0;
        for (n = 0; n < 400 && SINK.got.size() < exp_q.size(); n++) begin
            @(posedge i_mclk);
        end
        if (n == 400) begin
            bad_count++;
            finish_test();
        end
        repeat (3) @(posedge i_mclk);
        check(SINK.got.size(), exp_q.size());
        foreach (exp_q[i]) begin
            check(SINK.got[i], exp_q[i]);
        end
        exp_q.delete();
        SINK.got.delete();
    endtask

    task automatic t_reset;
        check({o_word_ready, o_byte_valid, o_unit_known}, 32'h4);
        check(o_unit, 32'h0);
    endtask

    // back-to-back flow extremes and temperature readings, slow consumer
    task automatic t_readings;
        mode <= 2'h2;
        send(frd_pkg::KIND_FLOW, 16'hBEEF);
        send(frd_pkg::KIND_FLOW, 16'h8000);
        send(frd_pkg::KIND_FLOW, 16'h7FFF);
        send(frd_pkg::KIND_FLOW, 16'hE268);
        send(frd_pkg::KIND_TEMP, 16'h0000);
        send(frd_pkg::KIND_TEMP, 16'hFFFF);
        send(frd_pkg::KIND_TEMP, 16'h0FA0);
        drain();
        check(SINK.flow_slm, 32'h64);
        check(SINK.temp_c, 32'h14);
        mode <= 2'h0;
    endtask

    // unit words: fields, top-bit masking and recognition
    task automatic t_units;
        logic [15:0] tab[5] = '{16'h0148, 16'hE148, 16'h0149, 16'h0158, 16'h0248};
        foreach (tab[i]) begin
            send(frd_pkg::KIND_UNIT, tab[i]);
            drain();
            check(o_unit, tab[i][12:0]);
            check(o_unit_known, i < 2);
            check(SINK.unit_ok, i < 2);
        end
    endtask

    // stalled consumer: fill the buffer until refused, then drain
    task automatic t_fill;
        int cnt;
        bit ok;
        cnt = 0;
        ok = 1'b1;
        mode <= 2'h1;
        for (int k = 0; k < 20 && ok; k++) begin
            push({frd_pkg::KIND_FLOW, 16'(k * 16'h1111)}, 4, ok);
            cnt += ok;
        end
        check(o_word_ready, 1'b0);
        check(cnt >= 16 && cnt <= 17, 1'b1);
        mode <= 2'h0;
        drain();
        check(o_word_ready, 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        t_reset();
        t_readings();
        t_units();
        t_fill();
        finish_test();
    end
endmodule
